// ==== shared/rsq_map.vh ====
// reset sequencer constants: register offsets, field positions, reset values, timing counts
// assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus
`ifndef RSQ_MAP_VH
`define RSQ_MAP_VH

// clock period in ns
`define RSQ_CLK_PERIOD_NS     10
// reset-out extension after an external request releases, in clocks
`define RSQ_EXT_TAIL_CLK      32
// watchdog internal reset length, in clocks (least)
`define RSQ_WDG_RST_CLK       31
// reset-out extension after the watchdog reset ends, in clocks (least)
`define RSQ_WDG_TAIL_CLK      31
// synchroniser depth
`define RSQ_SYNC_STAGES       2
// counter width
`define RSQ_CNT_W             6

// register byte offsets
`define RSQ_CAUSE_OFS         8'h00
`define RSQ_CTRL_OFS          8'h04
`define RSQ_BOOT_OFS          8'h08
`define RSQ_STAT_OFS          8'h0C

// cause register fields
`define RSQ_CAUSE_HARD_BIT    7
`define RSQ_CAUSE_SOFT_BIT    5
// control register fields
`define RSQ_CTRL_WDG_RST_BIT  0
`define RSQ_CTRL_SYSTEM_RESET_OUT_EN_BIT  1
`define RSQ_CTRL_RESET        2'h3
// cause register reset value: hard cause set
`define RSQ_CAUSE_RESET       2'h2

// sequencer states
`define RSQ_ST_IDLE           3'h0
`define RSQ_ST_EXT            3'h1
`define RSQ_ST_EXT_TAIL       3'h2
`define RSQ_ST_WDG            3'h3
`define RSQ_ST_WDG_TAIL       3'h4
`define RSQ_ST_WAIT_BUS       3'h5

// axi response codes
`define RSQ_RESP_OKAY         2'h0
`define RSQ_RESP_SLVERR       2'h2

`endif

// ==== logic/rsq_reset_sequencer.v ====
// reset sequencer: classifies master, normal and watchdog resets and drives reset outputs
// assumes reset-request inputs are active low pins on sys_clk; nrst is the power-on core reset
// assumes the board honours the six-clock minimum and moves the request pins as described below
// assumes the bus arbiter answers with bus_granted and first_exception_cycle after reset-out
// limitation: the control register is reached only over the axi4-lite slave port
// Overview of operation
// - master reset clears everything, DRAM controller too, and aborts refresh cycles
// - normal reset spares DRAM controller so refresh keeps memory contents
// - request and tristate request asserted together mean master reset
// - request asserted with tristate request negated means normal reset
// - both request inputs pass a two-clock synchroniser before use
// - reset-out follows the request and stays 32 clocks after release
// - during reset outputs float until bus granted and first exception cycle
// - normal reset stops bus activity except DRAM refresh
// - external reset sets hard cause flag, clears soft cause flag
// - priority pins captured on last edge with request asserted, steer boot select; master reset pins captured only while tristate request also seen
// - watchdog timeout with reset enabled gives internal reset of 31 clocks
// - reset-out stays at least 31 clocks after watchdog reset ends
// - watchdog reset stops bus activity except DRAM refresh
// - watchdog reset clears hard cause flag and sets soft cause flag
// - priority pins not sampled during watchdog reset unless request arrives
`timescale 1ns/1ps
`default_nettype none
`include "rsq_map.vh"

module rsq_reset_sequencer (
    input  wire        sys_clk,
    input  wire        nrst,
    // board pins
    input  wire        reset_request_in_n,
    input  wire        tristate_request_in_n,
    input  wire [2:0]  priority_level_pins_n,
    output reg         system_reset_out_n,
    output wire        system_reset_out_oe,
    output reg         bus_float,
    input  wire        bus_granted,
    input  wire        first_exception_cycle,
    // watchdog and internal resets
    input  wire        watchdog_timeout,
    output reg         sys_reset_n,
    output reg         dram_reset_n,
    output reg         refresh_abort,
    output reg  [2:0]  boot_chip_select_control,
    // axi4-lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

    reg [`RSQ_SYNC_STAGES-1:0] req_sync_r;
    reg [`RSQ_SYNC_STAGES-1:0] hiz_sync_r;
    reg [2:0]                  ipl_meta_r;
    reg [2:0]                  ipl_sync_r;
    reg [2:0]                  state_r;
    reg [2:0]                  state_nxt;
    reg [`RSQ_CNT_W-1:0]       cnt_r;
    reg [`RSQ_CNT_W-1:0]       cnt_nxt;
    reg                        master_r;
    reg                        master_nxt;
    reg [1:0]                  cause_r;
    reg [1:0]                  ctrl_r;
    reg [2:0]                  ipl_hold_r;
    reg [31:0]                 rd_val;
    reg                        aw_have_r;
    reg [7:0]                  aw_addr_r;
    reg                        w_have_r;
    reg [31:0]                 w_data_r;
    reg [3:0]                  w_strb_r;

    wire req_act;
    wire hiz_act;
    wire ext_master;
    wire ext_normal;
    wire wdg_fire;
    wire wr_go;
    wire wr_hit;
    wire rd_ok;
    wire ipl_take;
    wire ipl_commit;
    wire nxt_quiet;
    wire nxt_idle;
    wire nxt_ext;
    wire nxt_wdg;

    // counter loads, cut to the counter width where they are used
    localparam [31:0] EXT_LOAD_W      = `RSQ_EXT_TAIL_CLK - 1;
    localparam [31:0] WDG_LOAD_W      = `RSQ_WDG_RST_CLK - 1;
    localparam [31:0] WDG_TAIL_LOAD_W = `RSQ_WDG_TAIL_CLK - 1;

    // cause flag codes {hard, soft}
    localparam [1:0] CAUSE_HARD = 2'h2;
    localparam [1:0] CAUSE_SOFT = 2'h1;

    // two-flop synchronisers; priority pins take the same depth to line up with the request
    always @(posedge sys_clk) begin
        if (!nrst) begin
            req_sync_r <= 2'h0;
            hiz_sync_r <= 2'h0;
            ipl_meta_r <= 3'h0;
            ipl_sync_r <= 3'h0;
        end else begin
            req_sync_r <= {req_sync_r[0], ~reset_request_in_n};
            hiz_sync_r <= {hiz_sync_r[0], ~tristate_request_in_n};
            ipl_meta_r <= ~priority_level_pins_n;
            ipl_sync_r <= ipl_meta_r;
        end
    end

    assign req_act    = req_sync_r[1];
    assign hiz_act    = hiz_sync_r[1];
    assign ext_master = req_act & hiz_act;
    assign ext_normal = req_act & ~hiz_act;
    assign wdg_fire   = watchdog_timeout & ctrl_r[`RSQ_CTRL_WDG_RST_BIT];

    // pin capture while the request is held, with tristate request too in a master reset; applied when request release is seen
    assign ipl_take   = (state_r == `RSQ_ST_EXT) & req_act & (~master_r | hiz_act);
    assign ipl_commit = (state_r == `RSQ_ST_EXT) & ~req_act;

    // sequencer next state
    //   idle, wait_bus -> ext on a seen request, master if tristate request also seen
    //   idle, wait_bus -> wdg on a timeout while watchdog reset is enabled
    //   ext            -> ext_tail once the request is seen released
    //   ext_tail       -> wait_bus after the tail count; a new request restarts ext
    //   wdg            -> wdg_tail after the internal reset count
    //   wdg_tail       -> wait_bus after its count; a request turns either into ext
    //   wait_bus       -> idle when the bus is granted and the first exception cycle runs
    // a timeout during an external reset or a tail is ignored
    always @* begin
        state_nxt  = state_r;
        cnt_nxt    = cnt_r;
        master_nxt = master_r;
        case (state_r)
            `RSQ_ST_IDLE, `RSQ_ST_WAIT_BUS: begin
                if (req_act) begin
                    state_nxt  = `RSQ_ST_EXT;
                    master_nxt = hiz_act;
                end else if (wdg_fire) begin
                    state_nxt  = `RSQ_ST_WDG;
                    master_nxt = 1'b0;
                    cnt_nxt    = WDG_LOAD_W[`RSQ_CNT_W-1:0];
                end else if (state_r == `RSQ_ST_WAIT_BUS && bus_granted
                             && first_exception_cycle) begin
                    state_nxt = `RSQ_ST_IDLE;
                end
            end
            `RSQ_ST_EXT: begin
                if (ext_master)
                    master_nxt = 1'b1;
                if (!req_act) begin
                    state_nxt = `RSQ_ST_EXT_TAIL;
                    cnt_nxt   = EXT_LOAD_W[`RSQ_CNT_W-1:0];
                end
            end
            `RSQ_ST_EXT_TAIL, `RSQ_ST_WDG_TAIL: begin
                if (req_act) begin
                    state_nxt  = `RSQ_ST_EXT;
                    master_nxt = hiz_act;
                end else if (cnt_r == 6'h00) begin
                    state_nxt  = `RSQ_ST_WAIT_BUS;
                    master_nxt = 1'b0;
                end else begin
                    cnt_nxt = cnt_r - 6'h01;
                end
            end
            `RSQ_ST_WDG: begin
                if (req_act) begin
                    state_nxt  = `RSQ_ST_EXT;
                    master_nxt = hiz_act;
                end else if (cnt_r == 6'h00) begin
                    state_nxt = `RSQ_ST_WDG_TAIL;
                    cnt_nxt   = WDG_TAIL_LOAD_W[`RSQ_CNT_W-1:0];
                end else begin
                    cnt_nxt = cnt_r - 6'h01;
                end
            end
            default: begin
                state_nxt = `RSQ_ST_IDLE;
            end
        endcase
    end

    // sequencer registers
    always @(posedge sys_clk) begin
        if (!nrst) begin
            state_r  <= `RSQ_ST_WAIT_BUS;
            cnt_r    <= 6'h00;
            master_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            master_r <= master_nxt;
        end
    end

    // next-state groups that steer the reset outputs
    assign nxt_quiet = (state_nxt == `RSQ_ST_IDLE)
                       || (state_nxt == `RSQ_ST_WAIT_BUS);
    assign nxt_idle  = (state_nxt == `RSQ_ST_IDLE);
    assign nxt_ext   = (state_nxt == `RSQ_ST_EXT);
    assign nxt_wdg   = (state_nxt == `RSQ_ST_WDG);

    // reset outputs registered from the next state, so the pins never see decode glitches
    always @(posedge sys_clk) begin
        if (!nrst) begin
            system_reset_out_n <= 1'b1;
            sys_reset_n        <= 1'b0;
            dram_reset_n       <= 1'b0;
            refresh_abort      <= 1'b0;
            bus_float          <= 1'b1;
        end else begin
            system_reset_out_n <= nxt_quiet;
            sys_reset_n        <= nxt_quiet;
            dram_reset_n       <= ~(master_nxt & ~nxt_quiet);
            refresh_abort      <= master_nxt & nxt_ext;
            bus_float          <= ~nxt_idle;
        end
    end

    // cause flags: external reset sets hard, watchdog reset sets soft
    always @(posedge sys_clk) begin
        if (!nrst) begin
            cause_r <= `RSQ_CAUSE_RESET;
        end else if (nxt_ext) begin
            cause_r <= CAUSE_HARD;
        end else if (nxt_wdg) begin
            cause_r <= CAUSE_SOFT;
        end
    end

    // boot select: last pins seen with the request held, and tristate request too in a master reset, applied at its release
    always @(posedge sys_clk) begin
        if (!nrst) begin
            ipl_hold_r               <= 3'h0;
            boot_chip_select_control <= 3'h0;
        end else begin
            if (ipl_take)
                ipl_hold_r <= ipl_sync_r;
            if (ipl_commit)
                boot_chip_select_control <= ipl_hold_r;
        end
    end

    assign system_reset_out_oe = ctrl_r[`RSQ_CTRL_SYSTEM_RESET_OUT_EN_BIT];

    // axi4-lite write path: address and data taken in any order
    // one write at a time: a pending response holds both readies low
    assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_have_r & ~s_axi_bvalid;
    assign wr_go         = aw_have_r & w_have_r & ~s_axi_bvalid;
    assign wr_hit        = (aw_addr_r == `RSQ_CTRL_OFS);

    always @(posedge sys_clk) begin
        if (!nrst) begin
            aw_have_r    <= 1'b0;
            aw_addr_r    <= 8'h00;
            w_have_r     <= 1'b0;
            w_data_r     <= 32'h0;
            w_strb_r     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RSQ_RESP_OKAY;
            ctrl_r       <= `RSQ_CTRL_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `RSQ_RESP_OKAY : `RSQ_RESP_SLVERR;
                if (wr_hit && w_strb_r[0])
                    ctrl_r <= w_data_r[1:0];
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read mux
    //   cause  : hard and soft flags, read only
    //   ctrl   : watchdog reset enable and reset-out enable
    //   boot   : captured priority pins, read only
    //   status : master flag and sequencer state, read only
    always @* begin
        rd_val = 32'h0;
        case (s_axi_araddr)
            `RSQ_CAUSE_OFS: begin
                rd_val[`RSQ_CAUSE_HARD_BIT] = cause_r[1];
                rd_val[`RSQ_CAUSE_SOFT_BIT] = cause_r[0];
            end
            `RSQ_CTRL_OFS: rd_val[1:0] = ctrl_r;
            `RSQ_BOOT_OFS: rd_val[2:0] = boot_chip_select_control;
            `RSQ_STAT_OFS: rd_val[3:0] = {master_r, state_r};
            default: rd_val = 32'h0;
        endcase
    end

    assign s_axi_arready = ~s_axi_rvalid;

    // okay only for the four aligned register words; others read as zero
    assign rd_ok = (s_axi_araddr[7:4] == 4'h0) && (s_axi_araddr[1:0] == 2'h0);

    // axi4-lite read path
    always @(posedge sys_clk) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= `RSQ_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_ok ? `RSQ_RESP_OKAY : `RSQ_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ==== bench/rsq_seq_chk.sv ====
// checker for the reset sequencer: reset-out timing, dram reset, bus float, read channel
// assumes it is bound into rsq_reset_sequencer and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module rsq_seq_chk (
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        reset_request_in_n,
    input wire logic        tristate_request_in_n,
    input wire logic        bus_granted,
    input wire logic        first_exception_cycle,
    input wire logic        system_reset_out_n,
    input wire logic        bus_float,
    input wire logic        sys_reset_n,
    input wire logic        dram_reset_n,
    input wire logic        refresh_abort,
    input wire logic [2:0]  boot_chip_select_control,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    logic [7:0] low_r;
    // consecutive cycles with reset-out asserted
    always @(posedge sys_clk) begin
        if (!nrst || system_reset_out_n) begin
            low_r <= 8'h00;
        end else if (low_r != 8'hFF) begin
            low_r <= low_r + 8'h01;
        end
    end
    chk_ext_recog: assert property ((!reset_request_in_n) [*5] |-> !system_reset_out_n)
        else $error("reset-out late after request");
    chk_tail_len: assert property ($rose(system_reset_out_n) && $past(nrst) |-> $past(reset_request_in_n, 35))
        else $error("reset-out tail too short");
    chk_out_min: assert property ($rose(system_reset_out_n) && $past(nrst) |-> low_r >= 8'h26)
        else $error("reset-out pulse too short");
    chk_master_dram: assert property ((!reset_request_in_n && !tristate_request_in_n) [*5]
        |-> !dram_reset_n && refresh_abort) else $error("master reset spares dram");
    chk_normal_dram: assert property ($fell(dram_reset_n) && $past(nrst)
        |-> !$past(tristate_request_in_n, 2)) else $error("dram reset without master");
    chk_dram_sys: assert property (!dram_reset_n |-> !sys_reset_n)
        else $error("dram reset without system reset");
    chk_float_reset: assert property (!sys_reset_n || !system_reset_out_n |-> bus_float)
        else $error("bus driven during reset");
    chk_float_end: assert property ($fell(bus_float) |-> $past(bus_granted) && $past(first_exception_cycle))
        else $error("bus driven before grant");
    chk_boot_when: assert property ($changed(boot_chip_select_control) && $past(nrst)
        |-> !$past(system_reset_out_n)) else $error("boot select changed outside reset");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
endmodule
bind rsq_reset_sequencer rsq_seq_chk i_chk (.sys_clk, .nrst, .reset_request_in_n,
    .tristate_request_in_n, .bus_granted, .first_exception_cycle, .system_reset_out_n, .bus_float,
    .sys_reset_n, .dram_reset_n, .refresh_abort, .boot_chip_select_control, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata);
`default_nettype wire

// ==== bench/rsq_board_model.sv ====
// board model: reset request circuit and bus arbiter beside the sequencer
// assumes commands from the bench on sys_clk; request pins idle high on pull-ups
`timescale 1ns/1ps
`default_nettype none
module rsq_board_model (
    input  wire logic       sys_clk,
    input  wire logic       go,
    input  wire logic       master,
    input  wire logic [7:0] hold,
    input  wire logic       system_reset_out_n,
    output wire logic       reset_request_in_n,
    output wire logic       tristate_request_in_n,
    output wire logic       transfer_start_strobe_n,
    output wire logic       bus_granted,
    output wire logic       first_exception_cycle
);
    logic [7:0] cnt_r = 8'h00;
    logic [1:0] gnt_r = 2'h0;
    // request held at least six clocks whatever the bench asks
    always @(posedge sys_clk) begin
        if (go && cnt_r == 8'h00) begin
            cnt_r <= (hold < 8'h06) ? 8'h06 : hold;
        end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end
    assign reset_request_in_n = (cnt_r == 8'h00);
    assign tristate_request_in_n = !(master && cnt_r != 8'h00);
    assign transfer_start_strobe_n = 1'b1;
    // arbiter grants the bus two clocks after reset-out negates
    always @(posedge sys_clk) begin
        gnt_r <= (system_reset_out_n === 1'b1) ? {gnt_r[0], 1'b1} : 2'h0;
    end
    assign bus_granted = gnt_r[1];
    assign first_exception_cycle = gnt_r[1];
endmodule
`default_nettype wire

// ==== bench/tb_reset_sequencer.sv ====
// testbench for the reset sequencer: external, watchdog resets and register access
// assumes the board model drives the request pins and grants the bus
`timescale 1ns/1ps
`default_nettype none
`include "rsq_map.vh"
module tb_reset_sequencer;
    logic sys_clk = 1'b0, nrst = 1'b0, go = 1'b0, master = 1'b0, watchdog_timeout = 1'b0;
    logic [7:0] hold = 8'h0A, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0] priority_level_pins_n = 3'h7;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    wire logic reset_request_in_n, tristate_request_in_n, transfer_start_strobe_n, bus_granted;
    wire logic first_exception_cycle, system_reset_out_n, system_reset_out_oe, bus_float;
    wire logic sys_reset_n, dram_reset_n, refresh_abort, s_axi_awready, s_axi_wready;
    wire logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [2:0] boot_chip_select_control;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    int failures = 0, n_tests = 0, cyc = 0;
    rsq_board_model i_board (.sys_clk, .go, .master, .hold, .system_reset_out_n,
        .reset_request_in_n, .tristate_request_in_n, .transfer_start_strobe_n, .bus_granted,
        .first_exception_cycle);
    rsq_reset_sequencer i_dut (.sys_clk, .nrst, .reset_request_in_n, .tristate_request_in_n,
        .priority_level_pins_n, .system_reset_out_n, .system_reset_out_oe, .bus_float,
        .bus_granted, .first_exception_cycle, .watchdog_timeout, .sys_reset_n, .dram_reset_n,
        .refresh_abort, .boot_chip_select_control, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    always #5 sys_clk = ~sys_clk;
    task automatic results;
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    // write: offer address and data together, release each when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, hb;
        logic [1:0] r;
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge sys_clk);
            ta = s_axi_awready && s_axi_awvalid; tw = s_axi_wready && s_axi_wvalid;
            hb = s_axi_bvalid; r = s_axi_bresp;
            @(posedge sys_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (!hb);
        s_axi_bready <= 1'b0;
        check({30'h0, r}, {30'h0, er}, "bresp");
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ta, hr;
        logic [31:0] d;
        logic [1:0] r;
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        do begin
            @(negedge sys_clk);
            ta = s_axi_arready && s_axi_arvalid; hr = s_axi_rvalid; d = s_axi_rdata; r = s_axi_rresp;
            @(posedge sys_clk);
            if (ta) s_axi_arvalid <= 1'b0;
        end while (!hr);
        s_axi_rready <= 1'b0;
        check(d, ed, "rdata");
        check({30'h0, r}, {30'h0, er}, "rresp");
    endtask
    // length of the reset-out pulse, outputs sampled on its third cycle
    task automatic watch(output int n, output logic d, output logic a, output logic s);
        n = 0;
        while (system_reset_out_n !== 1'b0) @(negedge sys_clk);
        while (system_reset_out_n === 1'b0) begin
            n++;
            if (n == 3) begin
                d = dram_reset_n; a = refresh_abort; s = sys_reset_n;
                check(bus_float, 1'b1, "bus float");
            end
            @(negedge sys_clk);
        end
        @(posedge sys_clk);
    endtask
    task automatic ext(input logic m, input logic [2:0] p);
        int n;
        logic d, a, s;
        priority_level_pins_n <= p; master <= m; go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        watch(n, d, a, s);
        check(n >= 41 && n <= 44, 1'b1, "reset-out length");
        check(d, !m, "dram reset");
        check(a, m, "refresh abort");
        check(s, 1'b0, "system reset");
        check(boot_chip_select_control, {29'h0, ~p}, "boot select");
        axr(`RSQ_CAUSE_OFS, 32'h80, `RSQ_RESP_OKAY);
    endtask
    // cycle ceiling against a hang
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            $display("ERROR %0t run did not finish", $time);
            results();
        end
    end
    initial begin
        int n;
        logic d, a, s;
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        axr(`RSQ_CTRL_OFS, 32'h3, `RSQ_RESP_OKAY);
        check(system_reset_out_oe, 1'b1, "reset-out enable");
        ext(1'b1, 3'h6);
        ext(1'b0, 3'h1);
        priority_level_pins_n <= 3'h4; watchdog_timeout <= 1'b1;
        @(posedge sys_clk);
        watchdog_timeout <= 1'b0;
        watch(n, d, a, s);
        check(n >= 62 && n <= 65, 1'b1, "watchdog reset length");
        check(d, 1'b1, "dram kept");
        check(s, 1'b0, "system reset");
        check(boot_chip_select_control, 3'h6, "boot kept");
        axr(`RSQ_CAUSE_OFS, 32'h20, `RSQ_RESP_OKAY);
        axw(`RSQ_CTRL_OFS, 32'h2, `RSQ_RESP_OKAY);
        axr(`RSQ_CTRL_OFS, 32'h2, `RSQ_RESP_OKAY);
        watchdog_timeout <= 1'b1;
        @(posedge sys_clk);
        watchdog_timeout <= 1'b0;
        repeat (8) @(negedge sys_clk);
        check(system_reset_out_n, 1'b1, "watchdog refused");
        @(posedge sys_clk);
        axr(8'h10, 32'h0, `RSQ_RESP_SLVERR);
        axw(`RSQ_CAUSE_OFS, 32'h0, `RSQ_RESP_SLVERR);
        axw(`RSQ_CTRL_OFS, 32'h1, `RSQ_RESP_OKAY);
        check(system_reset_out_oe, 1'b0, "reset-out enable off");
        results();
    end
endmodule
`default_nettype wire
